// ===== pin_sync.sv
// Two-stage synchroniser for asynchronous panel pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_resetn,
	input  wire logic         i_ce,
	input  wire logic [W-1:0] i_pin,
	output logic      [W-1:0] o_level
);
	logic [W-1:0] meta;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta    <= '0;
			o_level <= '0;
		end else if (i_ce) begin
			meta    <= i_pin;
			o_level <= meta;
		end
	end
endmodule

// ===== recorder_command_diagnostics.sv
// Command dispatch, power-up tests and manual diagnostics of the recorder
`timescale 1ns/1ps
module recorder_command_diagnostics
	import recorder_pkg::*;
#(
	parameter int          PAT_DELAY  = PAT_DELAY_CYC,
	parameter int          LIGHT_STEP = LIGHT_STEP_CYC,
	parameter int          NUM_LIGHTS = 6,
	parameter logic [15:0] ROM_TOP    = ROM_SUM_ADDR,
	parameter logic [24:0] MEM_FIRST  = DATA_MEM_START,
	parameter logic [24:0] MEM_LAST   = DATA_MEM_END
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_resetn,
	input  wire logic                  i_ce,
	input  wire logic                  i_btn_start,
	input  wire logic                  i_btn_halt,
	input  wire logic                  i_btn_continue,
	input  wire logic                  i_run_test,
	input  wire logic [3:0]            i_thumbwheel,
	output logic      [15:0]           o_rom_addr,
	input  wire logic [15:0]           i_rom_data,
	output logic                       o_self_start,
	output logic      [1:0]            o_self_sel,
	input  wire logic                  i_self_done,
	input  wire logic                  i_self_fail,
	output logic                       o_ext_start,
	output logic                       o_ext_test,
	output logic      [3:0]            o_ext_cmd,
	input  wire logic                  i_ext_done,
	output logic                       o_mem_clr_wr,
	output logic      [24:0]           o_mem_addr,
	output logic                       o_sync_clear,
	input  wire logic                  i_mem_full,
	input  wire logic                  i_par_valid,
	input  wire logic [31:0]           i_par_data,
	output logic                       o_par_valid,
	output logic      [31:0]           o_par_data,
	output logic      [2:0]            o_msg_sel,
	output logic      [3:0]            o_msg_index,
	input  wire logic [7:0]            i_msg_char,
	output logic                       o_disp_init,
	output logic                       o_disp_wr,
	output logic      [7:0]            o_disp_data,
	output logic      [NUM_LIGHTS-1:0] o_lights,
	output logic                       o_halt_flag,
	output logic                       o_continue_flag,
	output logic      [7:0]            o_diag_status,
	output logic      [7:0]            o_system_status,
	output logic                       o_idle
);
	if (NUM_LIGHTS < 2 || NUM_LIGHTS > 8 || PAT_DELAY < 1 || LIGHT_STEP < 1) begin : g_chk
		$error("recorder_command_diagnostics: unsupported parameter value");
	end
	if (MEM_LAST < MEM_FIRST || MEM_FIRST[0] != MEM_LAST[0]) begin : g_chk_mem
		$error("recorder_command_diagnostics: bad erase range");
	end

	typedef enum logic [3:0] {
		S_ROM_ADDR, S_ROM_ACC, S_SELF_REQ, S_SELF_WAIT, S_LIGHT, S_MSG, S_IDLE,
		S_EXT, S_ERASE, S_ERASE_END, S_DSP_SHOW, S_DSP_WAIT, S_PAR_SYNC,
		S_PAR_ECHO, S_LIT_DIAG
	} state_t;

	state_t      state;
	logic [3:0]  pins;
	logic [3:0]  wheel;
	logic [2:0]  btn_prev;
	logic        start_press;
	logic        halt_press;
	logic        cont_press;
	logic        cmd_go;
	logic [15:0] rom_sum;
	logic [31:0] timer;
	logic [2:0]  light_idx;
	logic        disp_req;
	logic        disp_busy;
	logic        disp_done;
	logic        mem_full;
	logic        mem_full_clr;
	logic        busy;

	////////////////////////////////////////////////////////////////////////
	// Panel inputs cross in through two flops before any logic sees them
	pin_sync #(.W(8)) u_sync (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_ce     (i_ce),
		.i_pin    ({i_btn_start, i_btn_halt, i_btn_continue, i_run_test, i_thumbwheel}),
		.o_level  ({pins, wheel})
	);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			btn_prev <= 3'h0;
		end else if (i_ce) begin
			btn_prev <= pins[3:1];
		end
	end

	assign start_press = pins[3] & ~btn_prev[2];
	assign halt_press  = pins[2] & ~btn_prev[1];
	assign cont_press  = pins[1] & ~btn_prev[0];
	// New commands are only accepted between commands
	assign cmd_go      = start_press && state == S_IDLE;
	assign o_idle      = state == S_IDLE;

	////////////////////////////////////////////////////////////////////////
	// Sticky flags; a press in the clearing cycle still sets the flag
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_halt_flag     <= 1'b0;
			o_continue_flag <= 1'b0;
			mem_full        <= 1'b0;
		end else if (i_ce) begin
			if (halt_press)
				o_halt_flag <= 1'b1;
			else if (cmd_go)
				o_halt_flag <= 1'b0;
			if (cont_press)
				o_continue_flag <= 1'b1;
			else if (cmd_go)
				o_continue_flag <= 1'b0;
			if (i_mem_full)
				mem_full <= 1'b1;
			else if (mem_full_clr)
				mem_full <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			busy <= 1'b0;
		end else if (i_ce) begin
			busy <= state == S_PAR_SYNC || state == S_PAR_ECHO ||
				state == S_DSP_SHOW || state == S_DSP_WAIT;
		end
	end

	always_comb begin
		o_system_status              = 8'h00;
		o_system_status[BUSY_BIT]    = busy;
		o_system_status[MEMFULL_BIT] = mem_full;
	end

	////////////////////////////////////////////////////////////////////////
	// Display engine: one init strobe, then exactly 16 character writes
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			disp_busy   <= 1'b0;
			disp_done   <= 1'b0;
			o_disp_init <= 1'b0;
			o_disp_wr   <= 1'b0;
			o_disp_data <= 8'h00;
			o_msg_index <= 4'h0;
		end else if (i_ce) begin
			o_disp_init <= 1'b0;
			o_disp_wr   <= 1'b0;
			disp_done   <= 1'b0;
			if (disp_req) begin
				o_disp_init <= 1'b1;
				disp_busy   <= 1'b1;
				o_msg_index <= 4'h0;
			end else if (disp_busy) begin
				o_disp_wr   <= 1'b1;
				o_disp_data <= i_msg_char;
				o_msg_index <= o_msg_index + 4'h1;
				if (o_msg_index == 4'(MSG_LEN - 5'h1)) begin
					disp_busy <= 1'b0;
					disp_done <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequencer: power-up tests, then command dispatch
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state         <= S_ROM_ADDR;
			rom_sum       <= 16'h0000;
			o_rom_addr    <= 16'h0000;
			o_diag_status <= 8'h00;
			o_self_start  <= 1'b0;
			o_self_sel    <= SELF_SERIAL;
			o_ext_start   <= 1'b0;
			o_ext_test    <= 1'b0;
			o_ext_cmd     <= 4'h0;
			o_mem_clr_wr  <= 1'b0;
			o_mem_addr    <= 25'h0;
			o_sync_clear  <= 1'b0;
			mem_full_clr  <= 1'b0;
			o_par_valid   <= 1'b0;
			o_par_data    <= 32'h0;
			o_msg_sel     <= MSG_STATUS;
			disp_req      <= 1'b0;
			timer         <= 32'h0;
			light_idx     <= 3'h0;
			o_lights      <= '0;
		end else if (i_ce) begin
			o_self_start <= 1'b0;
			o_ext_start  <= 1'b0;
			o_mem_clr_wr <= 1'b0;
			o_sync_clear <= 1'b0;
			mem_full_clr <= 1'b0;
			o_par_valid  <= 1'b0;
			disp_req     <= 1'b0;
			case (state)
			S_ROM_ADDR: begin
				state <= S_ROM_ACC;
			end
			S_ROM_ACC: begin
				if (o_rom_addr == ROM_TOP) begin
					if (i_rom_data != rom_sum)
						o_diag_status[DIAG_ROM_BIT] <= 1'b1;
					o_self_sel <= SELF_SERIAL;
					state      <= S_SELF_REQ;
				end else begin
					rom_sum    <= rom_sum + i_rom_data;
					o_rom_addr <= o_rom_addr + 16'h1;
					state      <= S_ROM_ADDR;
				end
			end
			S_SELF_REQ: begin
				// Serial engine runs a polled internal loopback
				o_self_start <= 1'b1;
				state        <= S_SELF_WAIT;
			end
			S_SELF_WAIT: begin
				if (i_self_done) begin
					if (i_self_fail)
						o_diag_status[o_self_sel] <= 1'b1;
					if (o_self_sel == SELF_SERIAL) begin
						o_self_sel <= SELF_PARALLEL;
						state      <= S_SELF_REQ;
					end else if (o_self_sel == SELF_PARALLEL) begin
						light_idx <= 3'h0;
						timer     <= 32'h0;
						o_lights  <= NUM_LIGHTS'(1);
						state     <= S_LIGHT;
					end else begin
						o_msg_sel <= MSG_STATUS;
						disp_req  <= 1'b1;
						state     <= S_MSG;
					end
				end
			end
			S_LIGHT: begin
				// Lights give no feedback, so no status bit is touched
				if (timer == 32'(LIGHT_STEP - 1)) begin
					timer     <= 32'h0;
					light_idx <= light_idx + 3'h1;
					o_lights  <= o_lights << 1;
					if (light_idx == 3'(NUM_LIGHTS - 1)) begin
						o_self_sel <= SELF_RAM;
						state      <= S_SELF_REQ;
					end
				end else begin
					timer <= timer + 32'h1;
				end
			end
			S_MSG: begin
				if (disp_done)
					state <= S_IDLE;
			end
			S_IDLE: begin
				if (cmd_go) begin
					o_ext_cmd  <= wheel;
					o_ext_test <= pins[0];
					timer      <= 32'h0;
					light_idx  <= 3'h0;
					o_mem_addr <= MEM_FIRST;
					o_msg_sel  <= 3'h1;
					// Codes follow the listed order in each position
					if (!pins[0]) begin
						case (wheel)
						CMD_RECEIVE, CMD_OUTPUT: begin
							o_ext_start <= 1'b1;
							state       <= S_EXT;
						end
						CMD_ERASE: state <= S_ERASE;
						default:   state <= S_IDLE;
						endcase
					end else begin
						case (wheel)
						DIAG_RAM, DIAG_SERIAL, DIAG_SWITCH: begin
							o_ext_start <= 1'b1;
							state       <= S_EXT;
						end
						DIAG_DISPLAY: begin
							disp_req <= 1'b1;
							state    <= S_DSP_SHOW;
						end
						DIAG_PARALLEL: state <= S_PAR_SYNC;
						DIAG_LIGHT: begin
							o_lights <= NUM_LIGHTS'(1);
							state    <= S_LIT_DIAG;
						end
						default: state <= S_IDLE;
						endcase
					end
				end
			end
			S_EXT: begin
				if (i_ext_done || o_halt_flag)
					state <= S_IDLE;
			end
			S_ERASE: begin
				// Step only after a word was written, so the first word is cleared too
				if (o_halt_flag) begin
					state <= S_IDLE;
				end else if (o_mem_clr_wr && o_mem_addr == MEM_LAST) begin
					state <= S_ERASE_END;
				end else begin
					o_mem_clr_wr <= 1'b1;
					if (o_mem_clr_wr)
						o_mem_addr <= o_mem_addr + MEM_STEP;
				end
			end
			S_ERASE_END: begin
				o_sync_clear <= 1'b1;
				mem_full_clr <= 1'b1;
				state        <= S_IDLE;
			end
			S_DSP_SHOW: begin
				if (disp_done) begin
					timer <= 32'h0;
					state <= S_DSP_WAIT;
				end
			end
			S_DSP_WAIT: begin
				if (o_halt_flag) begin
					state <= S_IDLE;
				end else if (timer == 32'(PAT_DELAY - 1)) begin
					o_msg_sel <= (o_msg_sel == NUM_TEXTS) ? 3'h1 : o_msg_sel + 3'h1;
					disp_req  <= 1'b1;
					state     <= S_DSP_SHOW;
				end else begin
					timer <= timer + 32'h1;
				end
			end
			S_PAR_SYNC: begin
				if (o_halt_flag)
					state <= S_IDLE;
				else if (i_par_valid && i_par_data == PAR_SYNC_CODE)
					state <= S_PAR_ECHO;
			end
			S_PAR_ECHO: begin
				if (o_halt_flag) begin
					state <= S_IDLE;
				end else if (i_par_valid) begin
					o_par_valid <= 1'b1;
					o_par_data  <= i_par_data;
				end
			end
			S_LIT_DIAG: begin
				if (o_halt_flag) begin
					o_lights <= '0;
					state    <= S_IDLE;
				end else if (timer == 32'(LIGHT_STEP - 1)) begin
					timer    <= 32'h0;
					// Rotate so the sequence keeps cycling until halted
					o_lights <= {o_lights[NUM_LIGHTS-2:0], o_lights[NUM_LIGHTS-1]};
				end else begin
					timer <= timer + 32'h1;
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule

// ===== recorder_command_diagnostics_bench.sv
// Self-checking bench of the recorder command dispatch block
`timescale 1ns/1ps
module recorder_command_diagnostics_bench;
	import recorder_pkg::*;
	localparam logic [24:0] LAST = DATA_MEM_START + 25'h8;
	logic        i_clk, i_resetn, i_ce, i_btn_start, i_btn_halt, i_btn_continue, i_run_test;
	logic        i_mem_full, i_par_valid, i_self_done, i_self_fail, i_ext_done, o_idle;
	logic        o_self_start, o_ext_start, o_ext_test, o_mem_clr_wr, o_sync_clear, o_par_valid;
	logic        o_disp_init, o_disp_wr, o_halt_flag, o_continue_flag;
	logic [1:0]  o_self_sel;
	logic [2:0]  o_msg_sel;
	logic [3:0]  i_thumbwheel, o_ext_cmd, o_msg_index;
	logic [5:0]  o_lights;
	logic [7:0]  i_msg_char, o_disp_data, o_diag_status, o_system_status;
	logic [15:0] i_rom_data, o_rom_addr;
	logic [24:0] o_mem_addr;
	logic [31:0] i_par_data, o_par_data;
	int          miscompares = 0;
	int          checked = 0;
	// A short checksum span keeps the power-up walk within the run budget
	recorder_command_diagnostics #(.PAT_DELAY(20), .LIGHT_STEP(4), .ROM_TOP(16'h00ff),
		.MEM_LAST(LAST)) u_dut (.*);
	recorder_panel_model #(.SUM_AT(16'h00ff)) u_model (
		.i_clk(i_clk), .i_rom_addr(o_rom_addr), .o_rom_data(i_rom_data),
		.i_self_start(o_self_start), .i_self_sel(o_self_sel), .o_self_done(i_self_done),
		.o_self_fail(i_self_fail), .i_ext_start(o_ext_start), .o_ext_done(i_ext_done),
		.i_msg_sel(o_msg_sel), .i_msg_index(o_msg_index), .o_msg_char(i_msg_char)
	);
	always #2.5 i_clk = ~i_clk;
	////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wait_on(ref logic s, input int n);
		int k;
		for (k = 0; k < n && s !== 1'b1; k++)
			@(negedge i_clk);
		if (k == n) begin
			miscompares++;
			final_report();
		end
	endtask
	// A one-cycle pin pulse is enough for the synchroniser to see a press
	task automatic press(ref logic b);
		@(negedge i_clk) b = 1'b1;
		@(negedge i_clk) b = 1'b0;
		@(negedge i_clk);
	endtask
	task automatic cmd(input logic t, input logic [3:0] c);
		@(negedge i_clk) i_run_test = t;
		i_thumbwheel = c;
		repeat (3) @(negedge i_clk);
		press(i_btn_start);
	endtask
	////////////////////////////////////////
	task automatic t_flags();
		press(i_btn_halt);
		press(i_btn_continue);
		repeat (3) @(negedge i_clk);
		chk({o_halt_flag, o_continue_flag, o_idle}, 3'h7);
	endtask
	task automatic t_ext();
		logic [4:0] tab [5] = '{5'h00, 5'h01, 5'h10, 5'h11, 5'h15};
		foreach (tab[i]) begin
			cmd(tab[i][4], tab[i][3:0]);
			wait_on(o_ext_start, 4);
			chk({o_ext_test, o_ext_cmd}, tab[i]);
			wait_on(o_idle, 20);
		end
		cmd(1'b0, 4'h3);
		repeat (4) @(negedge i_clk);
		chk({o_ext_start, o_idle}, 2'h1);
	endtask
	task automatic t_erase();
		int n;
		@(negedge i_clk) i_mem_full = 1'b1;
		@(negedge i_clk) i_mem_full = 1'b0;
		chk(o_system_status, 8'h04);
		cmd(1'b0, CMD_ERASE);
		wait_on(o_mem_clr_wr, 4);
		for (n = 0; o_mem_clr_wr === 1'b1; n++) begin
			chk(o_mem_addr, DATA_MEM_START + MEM_STEP * n);
			@(negedge i_clk);
		end
		chk(n, 5);
		wait_on(o_sync_clear, 2);
		repeat (2) @(negedge i_clk);
		chk({o_idle, o_system_status}, 9'h100);
	endtask
	task automatic t_disp();
		cmd(1'b1, DIAG_DISPLAY);
		for (int p = 0; p < 8; p++) begin
			wait_on(o_disp_init, 30);
			chk(o_system_status, 8'h20);
			for (int k = 0; k < 16; k++) begin
				@(negedge i_clk);
				chk({o_disp_wr, o_disp_data}, {2'h2, 3'(p % 7 + 1), 4'(k)});
			end
			repeat (17) begin
				@(negedge i_clk);
				chk({o_disp_wr, o_disp_init}, 2'h0);
			end
		end
		press(i_btn_halt);
		wait_on(o_idle, 60);
		// Busy is registered and drops one cycle after the exit
		@(negedge i_clk);
		chk(o_system_status, 8'h00);
	endtask
	task automatic send(input logic [31:0] d, input logic echo);
		@(negedge i_clk) i_par_valid = 1'b1;
		i_par_data = d;
		@(negedge i_clk) i_par_valid = 1'b0;
		i_par_data = ~d;
		chk(o_par_valid, echo);
		if (echo)
			chk(o_par_data, d);
	endtask
	task automatic t_par();
		cmd(1'b1, DIAG_PARALLEL);
		repeat (2) @(negedge i_clk);
		chk(o_system_status, 8'h20);
		// Patterns only after the echo side is armed
		send(32'h01010101, 1'b0);
		send(PAR_SYNC_CODE, 1'b0);
		send(32'h0f0f0f0f, 1'b1);
		send(32'h0e0e0e0e, 1'b1);
		press(i_btn_halt);
		wait_on(o_idle, 20);
		@(negedge i_clk);
		chk(o_system_status, 8'h00);
	endtask
	task automatic t_light();
		cmd(1'b1, DIAG_LIGHT);
		for (int k = 0; k < 8 && o_lights === 6'h00; k++)
			@(negedge i_clk);
		chk(o_lights, 6'h01);
		repeat (4) @(negedge i_clk);
		chk(o_lights, 6'h02);
		press(i_btn_halt);
		wait_on(o_idle, 20);
		chk(o_lights, 6'h00);
	endtask
	////////////////////////////////////////
	initial begin
		{i_clk, i_resetn, i_btn_start, i_btn_halt, i_btn_continue} = 5'h00;
		{i_run_test, i_mem_full, i_par_valid, i_thumbwheel, i_par_data} = '0;
		i_ce = 1'b1;
		repeat (4) @(negedge i_clk);
		i_resetn = 1'b1;
		wait_on(o_idle, 2000);
		chk({o_lights, o_diag_status}, 14'h000b);
		t_flags();
		t_ext();
		t_erase();
		t_disp();
		t_par();
		t_light();
		final_report();
	end
endmodule

// ===== recorder_command_diagnostics_chk.sv
// Port checker of the recorder command dispatch block
`timescale 1ns/1ps
module recorder_command_diagnostics_chk
	import recorder_pkg::*;
#(
	parameter int NUM_LIGHTS = 6
) (
	input logic                  i_clk,
	input logic                  i_resetn,
	input logic                  i_ce,
	input logic                  i_btn_halt,
	input logic                  i_par_valid,
	input logic [31:0]           i_par_data,
	input logic                  o_par_valid,
	input logic [31:0]           o_par_data,
	input logic                  o_disp_init,
	input logic                  o_disp_wr,
	input logic                  o_mem_clr_wr,
	input logic [24:0]           o_mem_addr,
	input logic [NUM_LIGHTS-1:0] o_lights,
	input logic                  o_halt_flag,
	input logic [7:0]            o_diag_status,
	input logic [7:0]            o_system_status
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	////////////////////////////////////////
	sequence eight_writes;
		o_disp_wr [*8];
	endsequence
	chk_disp_sixteen: assert property (o_disp_init |=> eight_writes ##1 eight_writes ##1 !o_disp_wr)
		else $error("display update is not sixteen writes");
	// Sync stages make the press land a few edges late
	chk_halt_press: assert property (i_ce && $rose(i_btn_halt) |-> ##[1:4] o_halt_flag)
		else $error("halt press did not set the flag");
	chk_echo_data: assert property (o_par_valid |-> $past(i_par_valid) && o_par_data == $past(i_par_data))
		else $error("echo does not match received word");
	chk_echo_busy: assert property (o_par_valid |-> o_system_status[BUSY_BIT])
		else $error("echo while busy bit low");
	chk_erase_step: assert property (o_mem_clr_wr && $past(o_mem_clr_wr) |-> o_mem_addr == $past(o_mem_addr) + MEM_STEP)
		else $error("erase address step wrong");
	chk_diag_sticky: assert property (($past(o_diag_status) & ~o_diag_status) == 8'h00)
		else $error("failure bit cleared");
	chk_diag_rsvd: assert property (o_diag_status[7:4] == 4'h0)
		else $error("undefined failure bit set");
	chk_lights_one: assert property ($onehot0(o_lights))
		else $error("more than one light on");
endmodule

bind recorder_command_diagnostics recorder_command_diagnostics_chk #(.NUM_LIGHTS(NUM_LIGHTS)) u_chk (
	.i_clk, .i_resetn, .i_ce, .i_btn_halt, .i_par_valid, .i_par_data, .o_par_valid, .o_par_data,
	.o_disp_init, .o_disp_wr, .o_mem_clr_wr, .o_mem_addr, .o_lights, .o_halt_flag, .o_diag_status,
	.o_system_status
);

// ===== recorder_panel_model.sv
// Far-side model: program ROM, self-test and command engines, message text
`timescale 1ns/1ps
module recorder_panel_model
	import recorder_pkg::*;
#(
	parameter logic [15:0] SUM_AT   = ROM_SUM_ADDR,
	parameter logic [15:0] SUM_WORD = 16'h1234
) (
	input  wire logic        i_clk,
	input  wire logic [15:0] i_rom_addr,
	output logic      [15:0] o_rom_data,
	input  wire logic        i_self_start,
	input  wire logic [1:0]  i_self_sel,
	output logic             o_self_done,
	output logic             o_self_fail,
	input  wire logic        i_ext_start,
	output logic             o_ext_done,
	input  wire logic [2:0]  i_msg_sel,
	input  wire logic [3:0]  i_msg_index,
	output logic      [7:0]  o_msg_char
);
	logic [2:0] self_cnt = 3'h0;
	logic [2:0] ext_cnt  = 3'h0;
	// Words below the sum address add up to that address, so this sum word mismatches
	assign o_rom_data  = (i_rom_addr == SUM_AT) ? SUM_WORD : 16'h0001;
	assign o_msg_char  = {1'b0, i_msg_sel, i_msg_index};
	assign o_self_done = (self_cnt == 3'h1);
	// Only the parallel engine passes; off the done pulse the level is junk
	assign o_self_fail = o_self_done ^ (i_self_sel == SELF_PARALLEL);
	assign o_ext_done  = (ext_cnt == 3'h1);
	always @(posedge i_clk) begin
		self_cnt <= i_self_start ? 3'h4 : self_cnt - {2'h0, |self_cnt};
		ext_cnt  <= i_ext_start ? 3'h4 : ext_cnt - {2'h0, |ext_cnt};
	end
endmodule

// ===== recorder_pkg.sv
// Shared constants for the recorder command dispatch and diagnostics block
// Overview of operation
// - START press latches thumbwheels as command
// - HALT and CONTINUE presses set sticky flags
// - Run/test toggle picks operation or diagnostic processor
// - Command runs until done or halt flag
// - Run: receive, output, erase; test: six diagnostics
// - Diag status bits: ROM, serial, parallel, RAM
// - Power-up: ROM, serial, parallel, light, RAM, message
// - ROM checksum compared with word at FFFF
// - Parallel echo starts on FAF30001, ends on halt
// - Status bit 5 busy during parallel/display diagnostics
// - Seven display patterns, 3 s apart, until halt
// - Display update: initialise, then 16 message characters
// - Erase clears memory range, sync codes, memory full
// - Light test sequences lights, status byte untouched
// - Serial self-test is polled internal loopback
package recorder_pkg;
	localparam int          CLK_HZ         = 200_000_000;
	localparam int          PAT_DELAY_S    = 3;
	localparam int          PAT_DELAY_CYC  = PAT_DELAY_S * CLK_HZ;
	localparam int          LIGHT_STEP_MS  = 250;
	localparam int          LIGHT_STEP_CYC = LIGHT_STEP_MS * (CLK_HZ / 1000);
	localparam logic [15:0] ROM_SUM_ADDR   = 16'hffff;
	localparam logic [31:0] PAR_SYNC_CODE  = 32'hfaf30001;
	localparam logic [24:0] DATA_MEM_START = 25'h1000000;
	localparam logic [24:0] DATA_MEM_END   = 25'h107eefe;
	localparam logic [24:0] MEM_STEP       = 25'h0000002;
	localparam logic [4:0]  MSG_LEN        = 5'h10;
	localparam logic [2:0]  NUM_TEXTS      = 3'h7;
	localparam logic [2:0]  MSG_STATUS     = 3'h0;
	// Diagnostic and system status bit positions; self-test selects equal their bit
	localparam int          DIAG_ROM_BIT   = 0;
	localparam logic [1:0]  SELF_SERIAL    = 2'h1;
	localparam logic [1:0]  SELF_PARALLEL  = 2'h2;
	localparam logic [1:0]  SELF_RAM       = 2'h3;
	localparam int          BUSY_BIT       = 5;
	localparam int          MEMFULL_BIT    = 2;
	// Run position commands
	localparam logic [3:0]  CMD_RECEIVE    = 4'h0;
	localparam logic [3:0]  CMD_OUTPUT     = 4'h1;
	localparam logic [3:0]  CMD_ERASE      = 4'h2;
	// Test position commands
	localparam logic [3:0]  DIAG_RAM       = 4'h0;
	localparam logic [3:0]  DIAG_SERIAL    = 4'h1;
	localparam logic [3:0]  DIAG_DISPLAY   = 4'h2;
	localparam logic [3:0]  DIAG_PARALLEL  = 4'h3;
	localparam logic [3:0]  DIAG_LIGHT     = 4'h4;
	localparam logic [3:0]  DIAG_SWITCH    = 4'h5;
endpackage
